// *** hw/dac_load_pkg.sv ***
package dac_load_pkg;

    localparam int unsigned word_bits = 16;
    localparam int unsigned data_bits = 12;
    localparam int unsigned mode_bits = 2;
    // Bit positions inside the received word, first bit shifted in is bit 15
    localparam int unsigned mode_bit_high_pos = 13;
    localparam int unsigned mode_bit_low_pos = 12;
    localparam int unsigned data_msb_pos = 11;
    localparam logic [4:0] last_edge_count = 5'h0f;
    localparam logic [11:0] code_reset = 12'h000;
    localparam logic [1:0] mode_reset = 2'h0;
    localparam int unsigned sync_stages = 2;

    typedef enum logic [1:0]
    {
        mode_normal = 2'b00,
        mode_pd_1k = 2'b01,
        mode_pd_100k = 2'b10,
        mode_pd_tristate = 2'b11
    } op_mode_e;

endpackage : dac_load_pkg

// *** hw/dac_serial_load.sv ***
`timescale 1ns/1ps
`default_nettype none

module dac_serial_load (
    input wire logic mclk, // System clock, 20 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic sclk, // Serial clock from host, link domain
    input wire logic sync_n, // Frame select, active low
    input wire logic din, // Serial data
    output logic [11:0] dac_code, // Committed DAC code, mclk domain
    output logic [1:0] op_mode, // Committed mode, mclk domain
    output logic power_down, // High in any power-down mode
    output logic pd_1k, // Output tied down through 1k
    output logic pd_100k, // Output tied down through 100k
    output logic out_tristate, // Output open
    output logic update // One mclk pulse per committed frame
);

    // Link domain: frame select high holds the shift logic in reset, so a
    // rising edge aborts any partial word without needing an sclk edge.
    logic [15:0] shift;
    logic [4:0] count;
    logic done;
    logic commit_toggle;
    logic [13:0] held_word;

    wire frame_rst_n = arst_n & ~sync_n;
    wire [15:0] next_shift = {shift[14:0], din};
    wire last_edge = (count == dac_load_pkg::last_edge_count);

    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            shift <= '0;
            count <= '0;
            done <= 1'b0;
        end
        else if (!done)
        begin
            shift <= next_shift;
            count <= count + 5'h01;
            done <= last_edge;
        end
    end

    // Committed word and toggle survive the frame reset; only power-on
    // reset clears them.
    always_ff @(negedge sclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            held_word <= {dac_load_pkg::mode_reset, dac_load_pkg::code_reset};
            commit_toggle <= 1'b0;
        end
        else if (!sync_n && !done && last_edge)
        begin
            held_word <= next_shift[13:0];
            commit_toggle <= ~commit_toggle;
        end
    end

    logic got_word;
    logic [13:0] word;

    word_sync #(
        .width(14)
    ) u_word_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .toggle_in(commit_toggle),
        .word_in(held_word),
        .strobe(got_word),
        .word_out(word)
    );

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_code <= dac_load_pkg::code_reset;
            op_mode <= dac_load_pkg::mode_reset;
            update <= 1'b0;
        end
        else
        begin
            update <= got_word;
            if (got_word)
            begin
                dac_code <= word[dac_load_pkg::data_msb_pos:0];
                op_mode <= word[dac_load_pkg::mode_bit_high_pos:dac_load_pkg::mode_bit_low_pos];
            end
        end
    end

    wire is_1k = (op_mode == dac_load_pkg::mode_pd_1k);
    wire is_100k = (op_mode == dac_load_pkg::mode_pd_100k);
    wire is_tri = (op_mode == dac_load_pkg::mode_pd_tristate);

    assign power_down = (op_mode != dac_load_pkg::mode_normal);
    assign pd_1k = is_1k;
    assign pd_100k = is_100k;
    assign out_tristate = is_tri;

endmodule : dac_serial_load

`default_nettype wire

// *** hw/word_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Carries a word from the link domain with a toggle handshake.
// The word is held stable by the sender until the next toggle, so only
// the toggle needs two flip-flops; the word is sampled a cycle later.
module word_sync #(
    parameter int unsigned width = 14
) (
    input wire logic mclk, // System clock
    input wire logic arst_n, // Async reset, active low
    input wire logic toggle_in, // Toggles once per new word, link domain
    input wire logic [width-1:0] word_in, // Word held stable by sender
    output logic strobe, // One mclk pulse when word captured
    output logic [width-1:0] word_out // Captured word
);

    logic meta;
    logic sync;
    logic seen;
    wire new_word = sync ^ seen;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            seen <= 1'b0;
            strobe <= 1'b0;
            word_out <= '0;
        end
        else
        begin
            meta <= toggle_in;
            sync <= meta;
            seen <= sync;
            strobe <= new_word;
            if (new_word)
            begin
                word_out <= word_in;
            end
        end
    end

endmodule : word_sync

`default_nettype wire

// *** testbench/dac_serial_load_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_props (
    input wire logic mclk, // Clk
    input wire logic arst_n, // Rst
    input wire logic [11:0] dac_code, // Code
    input wire logic [1:0] op_mode, // Mode
    input wire logic power_down, // Off
    input wire logic pd_1k, // Low tie-down
    input wire logic pd_100k, // High tie-down
    input wire logic out_tristate, // Open
    input wire logic update); // Load
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_pulse;
        update ##1 !update;
    endsequence
    property p_pd; power_down == (op_mode != 2'h0); endproperty
    a_pd: assert property (p_pd) else $error("pd decode");
    property p_one; update |-> s_pulse; endproperty
    a_one: assert property (p_one) else $error("long update");
    property p_hold; $changed({op_mode, dac_code}) |-> update; endproperty
    a_hold: assert property (p_hold) else $error("silent change");
    property p_1k; pd_1k == (op_mode == 2'h1); endproperty
    a_1k: assert property (p_1k) else $error("1k decode");
    property p_100k; pd_100k == (op_mode == 2'h2); endproperty
    a_100k: assert property (p_100k) else $error("100k decode");
    property p_tri; out_tristate == (op_mode == 2'h3); endproperty
    a_tri: assert property (p_tri) else $error("tristate decode");
    property p_rst; $rose(arst_n) |-> !update && ({op_mode, dac_code} == 14'h0000); endproperty
    a_rst: assert property (p_rst) else $error("reset code");
endmodule : dac_serial_load_props
bind dac_serial_load dac_serial_load_props u_p (
    .mclk(mclk),
    .arst_n(arst_n),
    .dac_code(dac_code),
    .op_mode(op_mode),
    .power_down(power_down),
    .pd_1k(pd_1k),
    .pd_100k(pd_100k),
    .out_tristate(out_tristate),
    .update(update)
);
`default_nettype wire

// *** testbench/dac_serial_load_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_tb_top;
    logic mclk = 1'b0, arst_n = 1'b0;
    wire logic sclk, sync_n, din;
    wire logic [13:0] mc;
    int bad_count, comparisons, cycles;
    dac_serial_load DUT (.mclk, .arst_n, .sclk, .sync_n, .din, .dac_code(mc[11:0]),
        .op_mode(mc[13:12]), .power_down(), .pd_1k(), .pd_100k(), .out_tristate(), .update());
    host_serial_model host (.sclk, .sync_n, .din);
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
            give_verdict(1);
    end
    task automatic give_verdict(int late);
        $display("compares %0d errors %0d", comparisons, bad_count + late);
        if (bad_count + late == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic frame(logic [47:0] w, int n, logic [13:0] e);
        host.send(w, n);
        repeat (8) @(posedge mclk);
        #1 comparisons++;
        if (mc !== e)
        begin
            bad_count++;
            $display("[ERR] mode_code expected %h seen %h", e, mc);
        end
    endtask : frame
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
            frame({34'h3, 2'(m), {12{~m[0]}}}, 16, {2'(m), {12{~m[0]}}});
    endtask : t_modes
    task automatic t_power_on;
        @(posedge mclk);
        #1 frame(48'h0, 0, 14'h0000);
        frame(48'hffff_ffff_ffff, 15, 14'h0000);
    endtask : t_power_on
    task automatic t_abort;
        frame(48'hffff_ffff_ffff, 15, 14'h3000);
    endtask : t_abort
    task automatic t_extra;
        // 48 edges: a frame that kept counting would commit again on the 48th
        frame(48'h13c5_2a0f_3fff, 48, 14'h13c5);
    endtask : t_extra
    task automatic t_reset_mid;
        @(posedge mclk);
        #1 arst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 comparisons++;
        if (mc !== 14'h0000)
        begin
            bad_count++;
            $display("[ERR] reset_code expected %h seen %h", 14'h0000, mc);
        end
        arst_n = 1'b1;
        @(posedge mclk);
        #1 frame(48'hffff_ffff_ffff, 15, 14'h0000);
        frame(48'h2abc, 16, 14'h2abc);
    endtask : t_reset_mid
    initial
    begin
        repeat (4) @(posedge mclk);
        #1 arst_n = 1'b1;
        t_power_on();
        t_modes();
        t_abort();
        t_extra();
        t_reset_mid();
        give_verdict(0);
    end
endmodule : dac_serial_load_tb_top
`default_nettype wire

// *** testbench/host_serial_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    output logic sclk = 1'b1, // Clk
    output logic sync_n = 1'b1, // Frame
    output logic din = 1'b0); // Data
    task automatic send(logic [47:0] w, int n);
        sync_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din = w[i];
            #24 sclk = 1'b0;
            #24 sclk = 1'b1;
        end
        #24 sync_n = 1'b1;
        din = ~din; // No stale bit
    endtask : send
endmodule : host_serial_model
`default_nettype wire
